// file: rtl/mic_irq_ctrl.sv
module mic_irq_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire mic_pkg::mic_events_t events_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic irq_n_o,
  output logic irq_oe_o,
  output logic [7:0] enables_o,
  output mic_pkg::mic_ch1_t ch1_o
);

  // one access strobe matched against one register address
  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    reg_hit = strobe && (addr == target);
  endfunction : reg_hit

  // sticky flag: a set event wins over a clearing read in the same cycle
  function automatic logic sticky_flag(
    input logic held,
    input logic clear,
    input logic set
  );
    sticky_flag = (held && !clear) || set;
  endfunction : sticky_flag

  // held covers the first edge after reset release, which marks reset done
  typedef enum logic {
    BOOT_HELD = 1'h0,
    BOOT_RUN = 1'h1
  } mic_boot_t;

  mic_boot_t boot_r;
  mic_boot_t boot_nxt;
  logic [7:0] flags_cur;
  logic [7:0] flags_nxt;
  logic [7:0] enables_r;
  logic [7:0] ch1_r;
  logic [7:0] rdata_nxt;
  logic [7:0] pending;
  logic energy_msb_r;
  logic irq_nxt;

  // one flop per status bit keeps each set and clear path separate
  logic half_full_r;
  logic sag_r;
  logic cyc_done_r;
  logic wave_r;
  logic zero_cross_r;
  logic temp_r;
  logic reset_done_r;
  logic overflow_r;
  logic half_full_nxt;
  logic sag_nxt;
  logic cyc_done_nxt;
  logic wave_nxt;
  logic zero_cross_nxt;
  logic temp_nxt;
  logic reset_done_nxt;
  logic overflow_nxt;

  // register decode; unmapped reads return zero, unmapped writes are dropped
  logic rd_plain;
  logic rd_clear;
  logic rd_ch1;
  logic rd_en;
  logic wr_ch1;
  logic wr_en;
  assign rd_plain = reg_hit(rd_i, addr_i, mic_pkg::ADDR_FLAGS);
  assign rd_clear = reg_hit(rd_i, addr_i, mic_pkg::ADDR_FLAGS_CLR);
  assign rd_ch1 = reg_hit(rd_i, addr_i, mic_pkg::ADDR_CH1);
  assign rd_en = reg_hit(rd_i, addr_i, mic_pkg::ADDR_ENABLES);
  assign wr_ch1 = reg_hit(wr_i, addr_i, mic_pkg::ADDR_CH1);
  assign wr_en = reg_hit(wr_i, addr_i, mic_pkg::ADDR_ENABLES);

  // set requests, one per status bit except zero-crossing
  logic set_half_full;
  logic set_sag;
  logic set_cyc_done;
  logic set_wave;
  logic set_temp;
  logic set_reset_done;
  logic set_overflow;
  // hardware reset completion is the first clock after release
  assign set_reset_done = (boot_r == BOOT_HELD) || events_i.soft_reset_done;
  assign set_half_full = events_i.energy_msb && !energy_msb_r;
  assign set_sag = events_i.sag || events_i.no_zero_cross;
  assign set_cyc_done = events_i.cyc_done;
  assign set_wave = events_i.wave_sample;
  assign set_temp = events_i.temp_done;
  assign set_overflow = events_i.energy_overflow;

  // zero-crossing bit tracks its level and ignores the clearing read
  assign zero_cross_nxt = events_i.zero_cross;
  assign half_full_nxt = sticky_flag(half_full_r, rd_clear, set_half_full);
  assign sag_nxt = sticky_flag(sag_r, rd_clear, set_sag);
  assign cyc_done_nxt = sticky_flag(cyc_done_r, rd_clear, set_cyc_done);
  assign wave_nxt = sticky_flag(wave_r, rd_clear, set_wave);
  assign temp_nxt = sticky_flag(temp_r, rd_clear, set_temp);
  assign reset_done_nxt = sticky_flag(reset_done_r, rd_clear, set_reset_done);
  assign overflow_nxt = sticky_flag(overflow_r, rd_clear, set_overflow);

  always_comb begin
    flags_nxt = 8'h00;
    flags_nxt[mic_pkg::BIT_HALF_FULL] = half_full_nxt;
    flags_nxt[mic_pkg::BIT_SAG] = sag_nxt;
    flags_nxt[mic_pkg::BIT_CYC_DONE] = cyc_done_nxt;
    flags_nxt[mic_pkg::BIT_WAVE] = wave_nxt;
    flags_nxt[mic_pkg::BIT_ZERO_CROSS] = zero_cross_nxt;
    flags_nxt[mic_pkg::BIT_TEMP] = temp_nxt;
    flags_nxt[mic_pkg::BIT_RESET_DONE] = reset_done_nxt;
    flags_nxt[mic_pkg::BIT_OVERFLOW] = overflow_nxt;
  end

  always_comb begin
    flags_cur = 8'h00;
    flags_cur[mic_pkg::BIT_HALF_FULL] = half_full_r;
    flags_cur[mic_pkg::BIT_SAG] = sag_r;
    flags_cur[mic_pkg::BIT_CYC_DONE] = cyc_done_r;
    flags_cur[mic_pkg::BIT_WAVE] = wave_r;
    flags_cur[mic_pkg::BIT_ZERO_CROSS] = zero_cross_r;
    flags_cur[mic_pkg::BIT_TEMP] = temp_r;
    flags_cur[mic_pkg::BIT_RESET_DONE] = reset_done_r;
    flags_cur[mic_pkg::BIT_OVERFLOW] = overflow_r;
  end

  // bit 6 is masked out of the enable path entirely
  assign pending = flags_nxt & enables_r & mic_pkg::ENABLE_MASK;
  assign irq_nxt = ~|pending;

  // plain and clearing status addresses return the same flags
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_plain || rd_clear) begin
      rdata_nxt = flags_cur;
    end else if (rd_ch1) begin
      rdata_nxt = ch1_r;
    end else if (rd_en) begin
      rdata_nxt = enables_r;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  always_comb begin
    boot_nxt = boot_r;
    case (boot_r)
      BOOT_HELD: begin
        boot_nxt = BOOT_RUN;
      end
      BOOT_RUN: begin
        boot_nxt = BOOT_RUN;
      end
      default: begin
        boot_nxt = BOOT_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_r <= BOOT_HELD;
    end else begin
      boot_r <= boot_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      energy_msb_r <= 1'h0;
    end else begin
      energy_msb_r <= events_i.energy_msb;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      half_full_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_HALF_FULL];
    end else begin
      half_full_r <= half_full_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sag_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_SAG];
    end else begin
      sag_r <= sag_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_done_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_CYC_DONE];
    end else begin
      cyc_done_r <= cyc_done_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wave_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_WAVE];
    end else begin
      wave_r <= wave_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zero_cross_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_ZERO_CROSS];
    end else begin
      zero_cross_r <= zero_cross_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_TEMP];
    end else begin
      temp_r <= temp_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_done_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_RESET_DONE];
    end else begin
      reset_done_r <= reset_done_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_r <= mic_pkg::FLAGS_RESET[mic_pkg::BIT_OVERFLOW];
    end else begin
      overflow_r <= overflow_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enables_r <= mic_pkg::ENABLES_RESET;
    end else if (wr_en) begin
      enables_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ch1_r <= mic_pkg::CH1_RESET;
    end else if (wr_ch1) begin
      ch1_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // open drain: drive only while pulling low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_n_o <= 1'h1;
      irq_oe_o <= 1'h0;
    end else begin
      irq_n_o <= irq_nxt;
      irq_oe_o <= !irq_nxt;
    end
  end

  assign enables_o = enables_r;
  // bit 6 stored but unused by the channel
  assign ch1_o.integrator_on = ch1_r[mic_pkg::CH1_INTEG_BIT];
  assign ch1_o.offset_negative = ch1_r[mic_pkg::CH1_SIGN_BIT];
  assign ch1_o.offset_mag = ch1_r[4:0];
endmodule : mic_irq_ctrl

// file: rtl/mic_pkg.sv
package mic_pkg;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS_CLR = 8'h05;
  localparam logic [7:0] ADDR_CH1 = 8'h08;
  // enable register has no printed offset here
  localparam logic [7:0] ADDR_ENABLES = 8'h0A;
  localparam int BIT_HALF_FULL = 0;
  localparam int BIT_SAG = 1;
  localparam int BIT_CYC_DONE = 2;
  localparam int BIT_WAVE = 3;
  localparam int BIT_ZERO_CROSS = 4;
  localparam int BIT_TEMP = 5;
  localparam int BIT_RESET_DONE = 6;
  localparam int BIT_OVERFLOW = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] CH1_RESET = 8'h80;
  localparam logic [7:0] ENABLE_MASK = 8'hBF;
  localparam int CH1_INTEG_BIT = 7;
  localparam int CH1_SIGN_BIT = 5;

  typedef struct packed {
    logic energy_msb;
    logic sag;
    logic no_zero_cross;
    logic cyc_done;
    logic wave_sample;
    logic zero_cross;
    logic temp_done;
    logic soft_reset_done;
    logic energy_overflow;
  } mic_events_t;

  typedef struct packed {
    logic integrator_on;
    logic offset_negative;
    logic [4:0] offset_mag;
  } mic_ch1_t;
endpackage : mic_pkg

// file: bench/mic_host.sv
module mic_host (
  input wire logic irq_oe_i,
  output logic irq_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // board pull-up: the device only ever pulls the request line low
  assign irq_line_o = irq_oe_i ? 1'h0 : 1'h1;
endmodule : mic_host

// file: bench/mic_irq_ctrl_monitor.sv
module mic_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire mic_pkg::mic_events_t events_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_n_o,
  input wire logic irq_oe_o,
  input wire logic [7:0] enables_o,
  input wire mic_pkg::mic_ch1_t ch1_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_oe; irq_oe_o != irq_n_o; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_no; enables_o == 8'h00 && $stable(enables_o) |-> irq_n_o; endproperty
  a_no: assert property (p_no) else $error("no");
  property p_wv; events_i.wave_sample && enables_o[3] |=> !irq_n_o; endproperty
  a_wv: assert property (p_wv) else $error("wv");
  property p_ov; events_i.energy_overflow && enables_o[7] |=> !irq_n_o; endproperty
  a_ov: assert property (p_ov) else $error("ov");
  property p_zx; events_i.zero_cross && enables_o[4] |=> !irq_n_o; endproperty
  a_zx: assert property (p_zx) else $error("zx");
  property p_r6; enables_o == 8'h40 && $stable(enables_o) |-> irq_n_o; endproperty
  a_r6: assert property (p_r6) else $error("r6");
  property p_rb; rd_i && !wr_i && addr_i == mic_pkg::ADDR_CH1 |=>
    rdata_o[7] == ch1_o.integrator_on && rdata_o[5:0] == ch1_o[5:0]; endproperty
  a_rb: assert property (p_rb) else $error("rb");
  property p_wc; wr_i && addr_i == mic_pkg::ADDR_CH1 |=>
    ch1_o == {$past(wdata_i[7]), $past(wdata_i[5:0])}; endproperty
  a_wc: assert property (p_wc) else $error("wc");
endmodule : mic_chk
bind mic_irq_ctrl mic_chk mic_chk_i (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .events_i(events_i),
  .rd_i(rd_i),
  .wr_i(wr_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .irq_n_o(irq_n_o),
  .irq_oe_o(irq_oe_o),
  .enables_o(enables_o),
  .ch1_o(ch1_o)
);

// file: bench/tb_mic_irq_ctrl.sv
module tb_mic_irq_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, reset_n_i = 1'h0, rd_i = 1'h0, wr_i = 1'h0, irq_n_o, irq_oe_o, irq_w;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, enables_o;
  mic_pkg::mic_events_t events_i = '0;
  mic_pkg::mic_ch1_t ch1_o;
  int failures = 0, tests_run = 0;
  always #5 clk_i = ~clk_i;
  mic_irq_ctrl mic_irq_ctrl_i (.clk_i, .reset_n_i, .events_i, .rd_i, .wr_i, .addr_i,
    .wdata_i, .rdata_o, .irq_n_o, .irq_oe_o, .enables_o, .ch1_o);
  mic_host mic_host_i (.irq_oe_i(irq_oe_o), .irq_line_o(irq_w));
  task automatic chk(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk("rdata", rdata_o, e);
  endtask : rd
  // level events stay high across the read, pulses drop after one cycle
  task automatic ev(input logic [8:0] e, input logic [7:0] x);
    @(posedge clk_i);
    events_i <= e;
    @(posedge clk_i);
    events_i <= e & 9'h108;
    rd(mic_pkg::ADDR_FLAGS_CLR, x);
    @(posedge clk_i);
    events_i <= '0;
    rd(mic_pkg::ADDR_FLAGS_CLR, 8'h00);
  endtask : ev
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1;
    chk("ch1", 8'(ch1_o), 8'h40);
    rd(mic_pkg::ADDR_FLAGS, 8'h40);
    rd(mic_pkg::ADDR_FLAGS_CLR, 8'h40);
    rd(mic_pkg::ADDR_FLAGS, 8'h00);
    rd(8'h01, 8'h00);
    wr(mic_pkg::ADDR_ENABLES, 8'hFF);
    #1 chk("enables", enables_o, 8'hFF);
    rd(mic_pkg::ADDR_ENABLES, 8'hFF);
    ev(9'h100, 8'h01);
    ev(9'h080, 8'h02);
    ev(9'h040, 8'h02);
    ev(9'h020, 8'h04);
    ev(9'h010, 8'h08);
    ev(9'h008, 8'h10);
    ev(9'h004, 8'h20);
    ev(9'h002, 8'h40);
    ev(9'h001, 8'h80);
    wr(mic_pkg::ADDR_ENABLES, 8'h40);
    ev(9'h002, 8'h40);
    wr(mic_pkg::ADDR_ENABLES, 8'h08);
    @(posedge clk_i);
    events_i <= 9'h010;
    @(posedge clk_i);
    events_i <= '0;
    #1 chk("irq", 8'(irq_w), 8'h00);
    chk("irq_n", 8'(irq_n_o), 8'h00);
    rd(mic_pkg::ADDR_FLAGS_CLR, 8'h08);
    chk("irq", 8'(irq_w), 8'h01);
    chk("irq_n", 8'(irq_n_o), 8'h01);
    wr(mic_pkg::ADDR_CH1, 8'h65);
    rd(mic_pkg::ADDR_CH1, 8'h65);
    chk("ch1", 8'(ch1_o), 8'h25);
    give_verdict();
  end
endmodule : tb_mic_irq_ctrl
